// ===== tb_top.sv
// Testbench joining both ends and driving a second detector end directly.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic       clk_sys;
    logic       srst;
    logic       vbus;
    logic [1:0] ls;
    logic       idg;
    logic [2:0] meas;
    logic       lp1;
    logic       lp2;
    logic       start;
    logic       busy;
    logic       done;
    logic [2:0] code;
    logic       code_valid;
    logic       pu1_p;
    logic       pu1_m;
    logic       idpu1;
    logic       fs1;
    logic       pu2_p;
    logic       pu2_m;
    logic       fs2;
    logic [7:0] q;
    int         fail_count;
    int         n_tests;
    int         k;
    ucd_pkg::ucd_result_t res;
    logic [2:0] codes [7] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h7};
    logic [1:0] lss [3] = '{2'h3, 2'h0, 2'h1};

    ucd_if bus1();
    ucd_if bus2();
    // Short conversion keeps the run brief; polling bounds assume twenty cycles.
    ucd_phy #(.CONV_CYCLES(20)) u_ucd_phy (.clk_sys(clk_sys), .srst(srst), .lnk(bus1),
        .vbus_session(vbus), .line_state_bit0(ls[0]), .line_state_bit1(ls[1]),
        .id_grounded_flag(idg), .id_resistance_meas(meas), .low_power_req(lp1),
        .charger_pullup_plus_line(pu1_p), .charger_pullup_minus_line(pu1_m),
        .id_pullup_enable(idpu1), .fs_nondriving(fs1));
    ucd_link u_ucd_link (.clk_sys(clk_sys), .srst(srst), .phy(bus1), .start(start),
        .id_grounded_flag(idg), .busy(busy), .done(done), .result(res),
        .id_resistance_code(code), .code_valid(code_valid));
    ucd_phy #(.CONV_CYCLES(20)) u_ucd_phy_2 (.clk_sys(clk_sys), .srst(srst), .lnk(bus2),
        .vbus_session(vbus), .line_state_bit0(ls[0]), .line_state_bit1(ls[1]),
        .id_grounded_flag(idg), .id_resistance_meas(meas), .low_power_req(lp2),
        .charger_pullup_plus_line(pu2_p), .charger_pullup_minus_line(pu2_m),
        .id_pullup_enable(), .fs_nondriving(fs2));
    ucd_link_sva u_sva (.clk_sys(clk_sys), .srst(srst), .sync_mode(bus1.sync_mode),
        .rxcmd(bus1.rxcmd), .async_data(bus1.async_data), .wr_req(bus1.wr_req),
        .rd_req(bus1.rd_req), .addr(bus1.addr), .wdata(bus1.wdata), .ack(bus1.ack),
        .rdata(bus1.rdata), .wake_req(bus1.wake_req));

    always #2.5 clk_sys = ~clk_sys;

    task automatic conclude();
        if (fail_count == 0 && n_tests > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        n_tests++;
        if (g !== e) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic hang(input int n);
        if (n == 0) begin
            fail_count++;
            $display("[ERR] wait expired");
            conclude();
        end
    endtask

    // Request is held until the edge where ack is seen, then dropped at that edge.
    task automatic xfer(input logic w, input logic [5:0] a, input logic [7:0] d);
        int n;
        @(posedge clk_sys);
        bus2.addr <= a;
        bus2.wdata <= d;
        bus2.wr_req <= w;
        bus2.rd_req <= !w;
        n = 50;
        do begin
            @(posedge clk_sys);
            n--;
        end while (bus2.ack !== 1'b1 && n > 0);
        q = bus2.rdata;
        bus2.wr_req <= 1'b0;
        bus2.rd_req <= 1'b0;
        hang(n);
    endtask

    task automatic run_det(input logic [1:0] l, input ucd_pkg::ucd_result_t e);
        int n;
        ls <= l;
        @(posedge clk_sys);
        start <= 1'b1;
        @(posedge clk_sys);
        start <= 1'b0;
        n = 3000;
        do begin
            @(posedge clk_sys);
            n--;
        end while (done !== 1'b1 && n > 0);
        hang(n);
        chk("result", {6'h0, e}, {6'h0, res});
        chk("busy", 8'h00, {7'h0, busy});
        chk("pullups", 8'h03, {6'h0, pu1_m, pu1_p});
        chk("fs_nondriving", 8'h01, {7'h0, fs1});
    endtask

    initial begin
        clk_sys = 1'b0;
        srst = 1'b1;
        vbus = 1'b1;
        ls = 2'h2;
        idg = 1'b0;
        meas = 3'h0;
        lp1 = 1'b0;
        lp2 = 1'b0;
        start = 1'b0;
        fail_count = 0;
        n_tests = 0;
        bus2.wr_req = 1'b0;
        bus2.rd_req = 1'b0;
        bus2.addr = 6'h00;
        bus2.wdata = 8'h00;
        bus2.wake_req = 1'b0;
        repeat (2) @(posedge clk_sys);
        srst <= 1'b0;
        xfer(1'b0, ucd_pkg::FUNC_CTRL_ADDR, 8'h00);
        chk("func_ctrl", ucd_pkg::FUNC_CTRL_RST, q);
        xfer(1'b0, ucd_pkg::IO_PWR_ADDR, 8'h00);
        chk("io_pwr", ucd_pkg::IO_PWR_RST, q);
        xfer(1'b0, 6'h3f, 8'h00);
        chk("unmapped", 8'h00, q);
        xfer(1'b1, ucd_pkg::FUNC_CTRL_ADDR, ucd_pkg::FUNC_CTRL_CHG);
        repeat (2) @(posedge clk_sys);
        chk("fs2", 8'h01, {7'h0, fs2});
        xfer(1'b1, ucd_pkg::IO_PWR_SET_ADDR, ucd_pkg::PU_DP_MASK);
        repeat (2) @(posedge clk_sys);
        chk("pull_plus", 8'h01, {6'h0, pu2_m, pu2_p});
        xfer(1'b1, ucd_pkg::IO_PWR_SET_ADDR, ucd_pkg::PU_DM_MASK);
        repeat (2) @(posedge clk_sys);
        chk("pull_minus", 8'h03, {6'h0, pu2_m, pu2_p});
        xfer(1'b0, ucd_pkg::IO_PWR_ADDR, 8'h00);
        chk("io_pwr_set", 8'h34, q);
        xfer(1'b0, ucd_pkg::DEBUG_ADDR, 8'h00);
        chk("debug_ls", 8'h02, {6'h0, q[1:0]});
        chk("rxcmd", 8'h0a, bus2.rxcmd & 8'h0b);
        idg <= 1'b1;
        for (int i = 0; i < 7; i++) begin
            meas <= codes[i];
            xfer(1'b1, ucd_pkg::RID_CONV_ADDR + 6'h01, ucd_pkg::RID_GO_MASK);
            xfer(1'b0, ucd_pkg::RID_CONV_ADDR, 8'h00);
            chk("rid_early", 8'h00, {7'h0, q[3]});
            k = 20;
            do begin
                xfer(1'b0, ucd_pkg::RID_CONV_ADDR, 8'h00);
                k--;
            end while (q[3] !== 1'b1 && k > 0);
            hang(k);
            chk("rid_code", {5'h0, codes[i]}, {5'h0, q[2:0]});
            chk("rid_go", 8'h00, {7'h0, q[4]});
            xfer(1'b0, ucd_pkg::RID_CONV_ADDR, 8'h00);
            chk("rid_clear", 8'h00, {7'h0, q[3]});
        end
        idg <= 1'b0;
        lp2 <= 1'b1;
        repeat (5) @(posedge clk_sys);
        chk("async_ls", 8'h02, {5'h0, bus2.sync_mode, bus2.async_data[1:0]});
        chk("irq_idle", 8'h00, {7'h0, bus2.async_data[3]});
        vbus <= 1'b0;
        k = 50;
        do begin
            @(posedge clk_sys);
            k--;
        end while (bus2.async_data[3] !== 1'b1 && k > 0);
        hang(k);
        lp2 <= 1'b0;
        bus2.wake_req <= 1'b1;
        @(posedge clk_sys);
        bus2.wake_req <= 1'b0;
        k = 50;
        do begin
            @(posedge clk_sys);
            k--;
        end while (bus2.sync_mode !== 1'b1 && k > 0);
        hang(k);
        vbus <= 1'b1;
        repeat (20) @(posedge clk_sys);
        run_det(lss[0], ucd_pkg::UCD_CHGR);
        run_det(lss[1], ucd_pkg::UCD_HOST);
        run_det(lss[2], ucd_pkg::UCD_UNDET);
        idg <= 1'b1;
        meas <= ucd_pkg::RID_100K;
        run_det(2'h3, ucd_pkg::UCD_CHGR);
        chk("link_code", {4'h0, 1'b1, ucd_pkg::RID_100K}, {4'h0, code_valid, code});
        chk("id_pullup", 8'h01, {7'h0, idpu1});
        lp1 <= 1'b1;
        vbus <= 1'b0;
        idg <= 1'b0;
        repeat (3) @(posedge clk_sys);
        start <= 1'b1;
        @(posedge clk_sys);
        start <= 1'b0;
        k = 400;
        do begin
            @(posedge clk_sys);
            k--;
        end while (bus1.wake_req !== 1'b1 && k > 0);
        hang(k);
        lp1 <= 1'b0;
        repeat (20) @(posedge clk_sys);
        // A fresh interrupt in low power must wake the PHY again.
        lp1 <= 1'b1;
        repeat (5) @(posedge clk_sys);
        vbus <= 1'b1;
        k = 400;
        do begin
            @(posedge clk_sys);
            k--;
        end while (bus1.wake_req !== 1'b1 && k > 0);
        hang(k);
        lp1 <= 1'b0;
        k = 400;
        do begin
            @(posedge clk_sys);
            k--;
        end while (done !== 1'b1 && k > 0);
        hang(k);
        chk("wake_result", {6'h0, ucd_pkg::UCD_CHGR}, {6'h0, res});
        conclude();
    end
endmodule
`default_nettype wire

// ===== ucd_if.sv
// Register-access link between the PHY-side detector and the link controller.
`timescale 1ns/1ps
`default_nettype none
interface ucd_if;
    logic       sync_mode;
    logic [7:0] rxcmd;
    logic [7:0] async_data;
    logic       wr_req;
    logic       rd_req;
    logic [5:0] addr;
    logic [7:0] wdata;
    logic       ack;
    logic [7:0] rdata;
    logic       wake_req;
    modport phy (
        output sync_mode,
        output rxcmd,
        output async_data,
        input  wr_req,
        input  rd_req,
        input  addr,
        input  wdata,
        output ack,
        output rdata,
        input  wake_req
    );
    modport link (
        input  sync_mode,
        input  rxcmd,
        input  async_data,
        output wr_req,
        output rd_req,
        output addr,
        output wdata,
        input  ack,
        input  rdata,
        output wake_req
    );
endinterface
`default_nettype wire

// ===== ucd_link.sv
// Link end: runs ID resistance read and charger versus host detection.
`timescale 1ns/1ps
`default_nettype none
module ucd_link (
    input  wire logic clk_sys,
    input  wire logic srst,
    ucd_if.link       phy,
    input  wire logic start,
    input  wire logic id_grounded_flag,
    output logic      busy,
    output logic      done,
    output ucd_pkg::ucd_result_t result,
    output logic [2:0] id_resistance_code,
    output logic      code_valid
);
    typedef enum logic [3:0] {
        UCD_IDLE  = 4'b0000,
        UCD_SESS  = 4'b0001,
        UCD_WAKE  = 4'b0010,
        UCD_RDIRQ = 4'b0011,
        UCD_FUNC  = 4'b0100,
        UCD_PUDP  = 4'b0101,
        UCD_PUDM  = 4'b0110,
        UCD_LS    = 4'b0111,
        UCD_IDG   = 4'b1000,
        UCD_GO    = 4'b1001,
        UCD_POLL  = 4'b1010,
        UCD_FIN   = 4'b1011
    } ucd_state_t;

    ucd_state_t st_ff, nxt_st;
    logic       wr_ff, nxt_wr, rd_ff, nxt_rd, wake_ff, nxt_wake;
    logic [5:0] addr_ff, nxt_addr;
    logic [7:0] wd_ff, nxt_wd;
    logic       busy_ff, nxt_busy, done_ff, nxt_done, cv_ff, nxt_cv;
    logic [2:0] code_ff, nxt_code;
    ucd_pkg::ucd_result_t res_ff, nxt_res;
    logic       sess, irq, req;
    logic [1:0] ls;

    assign req  = wr_ff || rd_ff;
    assign sess = phy.sync_mode && phy.rxcmd[ucd_pkg::RXCMD_SESS_BIT];
    assign irq  = !phy.sync_mode && phy.async_data[ucd_pkg::INT_DATA_BIT];
    assign ls   = phy.sync_mode ? phy.rxcmd[1:0] : phy.async_data[1:0];

    always_comb begin
        nxt_st   = st_ff;
        nxt_wr   = wr_ff && !phy.ack;
        nxt_rd   = rd_ff && !phy.ack;
        nxt_wake = 1'b0;
        nxt_addr = addr_ff;
        nxt_wd   = wd_ff;
        nxt_busy = busy_ff;
        nxt_done = 1'b0;
        nxt_cv   = cv_ff;
        nxt_code = code_ff;
        nxt_res  = res_ff;
        case (st_ff)
            UCD_IDLE: begin
                if (start) begin
                    nxt_busy = 1'b1;
                    nxt_cv   = 1'b0;
                    nxt_res  = ucd_pkg::UCD_NONE;
                    nxt_st   = UCD_SESS;
                end
            end
            UCD_SESS: begin
                if (sess) begin
                    nxt_st   = UCD_FUNC;
                    nxt_wr   = 1'b1;
                    nxt_addr = ucd_pkg::FUNC_CTRL_ADDR;
                    nxt_wd   = ucd_pkg::FUNC_CTRL_CHG;
                end else if (irq) begin
                    nxt_wake = 1'b1;
                    nxt_st   = UCD_WAKE;
                end
            end
            UCD_WAKE: begin
                if (phy.sync_mode) begin
                    nxt_rd   = 1'b1;
                    nxt_addr = ucd_pkg::IRQ_STATUS_ADDR;
                    nxt_st   = UCD_RDIRQ;
                end else begin
                    // Every other cycle, so a granted wake is never repeated.
                    nxt_wake = !wake_ff;
                end
            end
            UCD_RDIRQ: begin
                if (req && phy.ack) begin
                    nxt_st = UCD_SESS;
                end
            end
            UCD_FUNC: begin
                if (req && phy.ack) begin
                    nxt_st   = UCD_PUDP;
                    nxt_wr   = 1'b1;
                    nxt_addr = ucd_pkg::IO_PWR_SET_ADDR;
                    nxt_wd   = ucd_pkg::PU_DP_MASK;
                end
            end
            UCD_PUDP: begin
                if (req && phy.ack) begin
                    nxt_st   = UCD_PUDM;
                    nxt_wr   = 1'b1;
                    nxt_addr = ucd_pkg::IO_PWR_SET_ADDR;
                    nxt_wd   = ucd_pkg::PU_DM_MASK;
                end
            end
            UCD_PUDM: begin
                if (req && phy.ack) begin
                    nxt_st = UCD_LS;
                end
            end
            UCD_LS: begin
                if (ls == ucd_pkg::LS_SE1) begin
                    nxt_res = ucd_pkg::UCD_CHGR;
                end else if (ls == ucd_pkg::LS_SE0) begin
                    nxt_res = ucd_pkg::UCD_HOST;
                end else begin
                    nxt_res = ucd_pkg::UCD_UNDET;
                end
                nxt_st = UCD_IDG;
            end
            UCD_IDG: begin
                if (id_grounded_flag) begin
                    nxt_wr   = 1'b1;
                    nxt_addr = ucd_pkg::RID_CONV_ADDR;
                    nxt_wd   = ucd_pkg::RID_IDPU_MASK | ucd_pkg::RID_GO_MASK;
                    nxt_st   = UCD_GO;
                end else begin
                    nxt_st = UCD_FIN;
                end
            end
            UCD_GO: begin
                if (req && phy.ack) begin
                    nxt_rd   = 1'b1;
                    nxt_addr = ucd_pkg::RID_CONV_ADDR;
                    nxt_st   = UCD_POLL;
                end
            end
            UCD_POLL: begin
                if (req && phy.ack) begin
                    if (phy.rdata[ucd_pkg::RID_DONE_BIT]) begin
                        nxt_code = phy.rdata[2:0];
                        nxt_cv   = 1'b1;
                        nxt_st   = UCD_FIN;
                    end else begin
                        nxt_rd = 1'b1;
                    end
                end
            end
            UCD_FIN: begin
                nxt_busy = 1'b0;
                nxt_done = 1'b1;
                nxt_st   = UCD_IDLE;
            end
            default: nxt_st = UCD_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            st_ff   <= UCD_IDLE;
            wr_ff   <= 1'b0;
            rd_ff   <= 1'b0;
            wake_ff <= 1'b0;
            addr_ff <= 6'h00;
            wd_ff   <= 8'h00;
            busy_ff <= 1'b0;
            done_ff <= 1'b0;
            cv_ff   <= 1'b0;
            code_ff <= ucd_pkg::RID_ZERO;
            res_ff  <= ucd_pkg::UCD_NONE;
        end else begin
            st_ff   <= nxt_st;
            wr_ff   <= nxt_wr;
            rd_ff   <= nxt_rd;
            wake_ff <= nxt_wake;
            addr_ff <= nxt_addr;
            wd_ff   <= nxt_wd;
            busy_ff <= nxt_busy;
            done_ff <= nxt_done;
            cv_ff   <= nxt_cv;
            code_ff <= nxt_code;
            res_ff  <= nxt_res;
        end
    end

    assign phy.wr_req   = wr_ff;
    assign phy.rd_req   = rd_ff;
    assign phy.addr     = addr_ff;
    assign phy.wdata    = wd_ff;
    assign phy.wake_req = wake_ff;
    assign busy               = busy_ff;
    assign done               = done_ff;
    assign result             = res_ff;
    assign id_resistance_code = code_ff;
    assign code_valid         = cv_ff;
endmodule
`default_nettype wire

// ===== ucd_link_sva.sv
// Protocol and ordering checks on the register link between the two ends.
`timescale 1ns/1ps
`default_nettype none
module ucd_link_sva (
    input wire logic       clk_sys,
    input wire logic       srst,
    input wire logic       sync_mode,
    input wire logic [7:0] rxcmd,
    input wire logic [7:0] async_data,
    input wire logic       wr_req,
    input wire logic       rd_req,
    input wire logic [5:0] addr,
    input wire logic [7:0] wdata,
    input wire logic       ack,
    input wire logic [7:0] rdata,
    input wire logic       wake_req
);
    logic fc_seen_ff;
    logic dp_seen_ff;
    logic go_seen_ff;
    logic nxt_fc_seen;
    logic nxt_dp_seen;
    logic nxt_go_seen;
    logic wr_done;

    // Flags stay set for the whole run, so a later detection pass is checked loosely.
    always_comb begin
        wr_done = wr_req && ack;
        nxt_fc_seen = fc_seen_ff || (wr_done && addr == ucd_pkg::FUNC_CTRL_ADDR
            && wdata == ucd_pkg::FUNC_CTRL_CHG);
        nxt_dp_seen = dp_seen_ff || (wr_done && addr == ucd_pkg::IO_PWR_SET_ADDR
            && wdata[ucd_pkg::PU_DP_BIT]);
        nxt_go_seen = go_seen_ff || (wr_done && wdata[ucd_pkg::RID_GO_BIT]
            && (addr == ucd_pkg::RID_CONV_ADDR || addr == ucd_pkg::RID_CONV_ADDR + 6'h01));
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            fc_seen_ff <= 1'b0;
            dp_seen_ff <= 1'b0;
            go_seen_ff <= 1'b0;
        end else begin
            fc_seen_ff <= nxt_fc_seen;
            dp_seen_ff <= nxt_dp_seen;
            go_seen_ff <= nxt_go_seen;
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (srst);

    a_ack_one_cycle: assert property (ack |=> !ack)
        else $error("ack lasted more than one cycle");
    a_ack_after_req: assert property ((wr_req || rd_req) && !ack |=> ack)
        else $error("request not answered in one cycle");
    a_ack_has_req: assert property (ack |-> $past(wr_req || rd_req))
        else $error("ack without a request");
    a_req_held: assert property ((wr_req || rd_req) && !ack |=> $stable(addr)
        && $stable(wdata) && $stable(wr_req) && $stable(rd_req))
        else $error("request changed before ack");
    a_plus_after_fc: assert property (wr_done && addr == ucd_pkg::IO_PWR_SET_ADDR
        && wdata[ucd_pkg::PU_DP_BIT] |-> fc_seen_ff)
        else $error("plus pull-up before non-driving setup");
    a_minus_after_plus: assert property (wr_done && addr == ucd_pkg::IO_PWR_SET_ADDR
        && wdata[ucd_pkg::PU_DM_BIT] |-> dp_seen_ff)
        else $error("minus pull-up before plus pull-up");
    a_rid_read_go: assert property (rd_req && addr == ucd_pkg::RID_CONV_ADDR
        |-> go_seen_ff)
        else $error("resistance read without conversion start");
    a_wake_async: assert property (wake_req |-> !sync_mode)
        else $error("wake request while synchronous");
    a_irq_wakes: assert property ($rose(async_data[ucd_pkg::INT_DATA_BIT]) && !sync_mode
        |-> ##[1:200] wake_req)
        else $error("interrupt not followed by wake");
    a_wake_reads: assert property (wake_req |-> ##[1:200]
        (rd_req && addr == ucd_pkg::IRQ_STATUS_ADDR))
        else $error("wake not followed by status read");
    a_rdata_holds: assert property ($fell(ack) |-> $stable(rdata))
        else $error("read data changed after ack");
endmodule
`default_nettype wire

// ===== ucd_phy.sv
// PHY end: charger pull-ups, ID resistance converter and line-state reporting.
`timescale 1ns/1ps
`default_nettype none
module ucd_phy #(
    parameter int CONV_CYCLES = ucd_pkg::RID_CONV_CYCLES
) (
    input  wire logic clk_sys,
    input  wire logic srst,
    ucd_if.phy        lnk,
    input  wire logic vbus_session,
    input  wire logic line_state_bit0,
    input  wire logic line_state_bit1,
    input  wire logic id_grounded_flag,
    input  wire logic [2:0] id_resistance_meas,
    input  wire logic low_power_req,
    output logic      charger_pullup_plus_line,
    output logic      charger_pullup_minus_line,
    output logic      id_pullup_enable,
    output logic      fs_nondriving
);
    logic [7:0]  func_ff, nxt_func;
    logic [7:0]  iop_ff, nxt_iop;
    logic        go_ff, nxt_go, done_ff, nxt_done, idpu_ff, nxt_idpu;
    logic [2:0]  code_ff, nxt_code;
    logic [31:0] cnt_ff, nxt_cnt;
    logic        lp_ff, nxt_lp, irq_ff, nxt_irq, sess_q_ff;
    logic        ack_ff, nxt_ack;
    logic [7:0]  rdat_ff, nxt_rdat, rx_ff, nxt_rx, as_ff, nxt_as;
    logic        wr, rd;

    assign wr = lnk.wr_req && !ack_ff;
    assign rd = lnk.rd_req && !ack_ff;

    always_comb begin
        nxt_func = func_ff;
        nxt_iop  = iop_ff;
        nxt_go   = go_ff;
        nxt_done = done_ff;
        nxt_idpu = idpu_ff;
        nxt_code = code_ff;
        nxt_cnt  = cnt_ff;
        nxt_lp   = lp_ff;
        nxt_irq  = irq_ff;
        nxt_ack  = wr || rd;
        nxt_rdat = rdat_ff;
        if (low_power_req) begin
            nxt_lp = 1'b1;
        end else if (lnk.wake_req) begin
            nxt_lp = 1'b0;
        end
        // Go auto-clears; a start written in the same cycle wins.
        if (go_ff && cnt_ff == 32'(CONV_CYCLES - 1)) begin
            nxt_go = 1'b0;
        end
        if (wr) begin
            if (lnk.addr == ucd_pkg::FUNC_CTRL_ADDR) begin
                nxt_func = lnk.wdata;
            end else if (lnk.addr == ucd_pkg::IO_PWR_ADDR) begin
                nxt_iop = lnk.wdata;
            end else if (lnk.addr == ucd_pkg::IO_PWR_SET_ADDR) begin
                nxt_iop = iop_ff | lnk.wdata;
            end else if (lnk.addr == ucd_pkg::IO_PWR_CLR_ADDR) begin
                nxt_iop = iop_ff & ~lnk.wdata;
            end else if (lnk.addr == ucd_pkg::RID_CONV_ADDR) begin
                nxt_idpu = lnk.wdata[ucd_pkg::IDPU_BIT];
                if (lnk.wdata[ucd_pkg::RID_GO_BIT]) begin
                    nxt_go = 1'b1;
                end
            end else if (lnk.addr == (ucd_pkg::RID_CONV_ADDR + 6'h01)) begin
                nxt_idpu = idpu_ff | lnk.wdata[ucd_pkg::IDPU_BIT];
                if (lnk.wdata[ucd_pkg::RID_GO_BIT]) begin
                    nxt_go = 1'b1;
                end
            end
        end
        if (rd) begin
            if (lnk.addr == ucd_pkg::FUNC_CTRL_ADDR) begin
                nxt_rdat = func_ff;
            end else if (lnk.addr >= ucd_pkg::IO_PWR_ADDR &&
                         lnk.addr <= ucd_pkg::IO_PWR_CLR_ADDR) begin
                nxt_rdat = iop_ff;
            end else if (lnk.addr == ucd_pkg::RID_CONV_ADDR) begin
                nxt_rdat = {3'h0, go_ff, done_ff, code_ff};
                nxt_done = 1'b0;
            end else if (lnk.addr == ucd_pkg::DEBUG_ADDR) begin
                nxt_rdat = {6'h00, line_state_bit1, line_state_bit0};
            end else if (lnk.addr == ucd_pkg::IRQ_STATUS_ADDR) begin
                nxt_rdat = {4'h0, irq_ff, 1'b0, id_grounded_flag, vbus_session};
                nxt_irq  = 1'b0;
            end else begin
                nxt_rdat = 8'h00;
            end
        end
        if (go_ff) begin
            if (cnt_ff == 32'(CONV_CYCLES - 1)) begin
                nxt_cnt  = 32'h0;
                nxt_done = 1'b1;
                nxt_code = id_resistance_meas;
            end else begin
                nxt_cnt = cnt_ff + 32'h1;
            end
        end
        if (vbus_session != sess_q_ff) begin
            nxt_irq = 1'b1;
        end
        nxt_rx = {4'h0, vbus_session, 1'b0, line_state_bit1, line_state_bit0};
        nxt_as = 8'h00;
        nxt_as[ucd_pkg::INT_DATA_BIT] = irq_ff;
        // Line state on bits zero, one.
        nxt_as[1:0] = {line_state_bit1, line_state_bit0};
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            func_ff   <= ucd_pkg::FUNC_CTRL_RST;
            iop_ff    <= ucd_pkg::IO_PWR_RST;
            go_ff     <= 1'b0;
            done_ff   <= 1'b0;
            idpu_ff   <= 1'b0;
            code_ff   <= ucd_pkg::RID_ZERO;
            cnt_ff    <= 32'h0;
            lp_ff     <= 1'b0;
            irq_ff    <= 1'b0;
            // Sampling the pin in reset avoids a false interrupt after release.
            sess_q_ff <= vbus_session;
            ack_ff    <= 1'b0;
            rdat_ff   <= 8'h00;
            rx_ff     <= 8'h00;
            as_ff     <= 8'h00;
            charger_pullup_plus_line  <= 1'b0;
            charger_pullup_minus_line <= 1'b0;
            id_pullup_enable          <= 1'b0;
            fs_nondriving             <= 1'b0;
        end else begin
            func_ff   <= nxt_func;
            iop_ff    <= nxt_iop;
            go_ff     <= nxt_go;
            done_ff   <= nxt_done;
            idpu_ff   <= nxt_idpu;
            code_ff   <= nxt_code;
            cnt_ff    <= nxt_cnt;
            lp_ff     <= nxt_lp;
            irq_ff    <= nxt_irq;
            sess_q_ff <= vbus_session;
            ack_ff    <= nxt_ack;
            rdat_ff   <= nxt_rdat;
            rx_ff     <= nxt_rx;
            as_ff     <= nxt_as;
            charger_pullup_plus_line  <= nxt_iop[ucd_pkg::PU_DP_BIT];
            charger_pullup_minus_line <= nxt_iop[ucd_pkg::PU_DM_BIT];
            id_pullup_enable          <= nxt_idpu;
            fs_nondriving <= (nxt_func == ucd_pkg::FUNC_CTRL_CHG);
        end
    end

    assign lnk.sync_mode  = !lp_ff;
    assign lnk.rxcmd      = rx_ff;
    assign lnk.async_data = as_ff;
    assign lnk.ack        = ack_ff;
    assign lnk.rdata      = rdat_ff;
endmodule
`default_nettype wire

// ===== ucd_pkg.sv
// Shared constants and types for the charger detection sequencer ends.
package ucd_pkg;
    localparam logic [5:0] FUNC_CTRL_ADDR    = 6'h04;
    localparam logic [5:0] IO_PWR_ADDR       = 6'h39;
    localparam logic [5:0] IO_PWR_SET_ADDR   = 6'h3a;
    localparam logic [5:0] IO_PWR_CLR_ADDR   = 6'h3b;
    localparam logic [5:0] RID_CONV_ADDR     = 6'h36;
    localparam logic [5:0] DEBUG_ADDR        = 6'h15;
    localparam logic [5:0] IRQ_STATUS_ADDR   = 6'h13;
    localparam logic [7:0] FUNC_CTRL_CHG     = 8'h49;
    localparam logic [7:0] FUNC_CTRL_RST     = 8'h41;
    localparam logic [7:0] IO_PWR_RST        = 8'h04;
    localparam int         PU_DP_BIT         = 4;
    localparam int         PU_DM_BIT         = 5;
    localparam int         RID_DONE_BIT      = 3;
    localparam int         RID_GO_BIT        = 4;
    localparam int         IDPU_BIT          = 0;
    localparam logic [7:0] RID_GO_MASK       = 8'h10;
    localparam logic [7:0] RID_IDPU_MASK     = 8'h01;
    localparam logic [7:0] PU_DP_MASK        = 8'h10;
    localparam logic [7:0] PU_DM_MASK        = 8'h20;
    localparam int         RXCMD_SESS_BIT    = 3;
    localparam int         INT_DATA_BIT      = 3;
    localparam int         CLK_MHZ           = 200;
    localparam int         RID_CONV_US       = 282;
    localparam int         RID_CONV_CYCLES   = RID_CONV_US * CLK_MHZ;
    localparam logic [2:0] RID_ZERO          = 3'h0;
    localparam logic [2:0] RID_75            = 3'h1;
    localparam logic [2:0] RID_100K          = 3'h2;
    localparam logic [2:0] RID_200K          = 3'h3;
    localparam logic [2:0] RID_440K          = 3'h4;
    localparam logic [2:0] RID_FLOAT         = 3'h5;
    localparam logic [2:0] RID_ERROR         = 3'h7;
    localparam logic [1:0] LS_SE0            = 2'h0;
    localparam logic [1:0] LS_SE1            = 2'h3;
    typedef enum logic [1:0] {
        UCD_NONE  = 2'b00,
        UCD_CHGR  = 2'b01,
        UCD_HOST  = 2'b10,
        UCD_UNDET = 2'b11
    } ucd_result_t;
endpackage
